// ===== hdl/addr_decode_pkg.sv
package addr_decode_pkg;
	// ****************************************
	// apb register map
	// ****************************************
	localparam int          PADDR_W       = 8;
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_SHADOW    = 8'h04;
	localparam logic [7:0]  OFS_TOM       = 8'h08;
	localparam logic [7:0]  OFS_MMIO      = 8'h0C;
	localparam logic [7:0]  OFS_APER      = 8'h10;
	localparam logic [7:0]  OFS_STATUS    = 8'h14;
	// control register fields
	localparam int          CTL_W         = 9;
	localparam int          B_CDHOLE      = 0;
	localparam int          B_ISAHOLE     = 1;
	localparam int          B_TOP_SMM_SEGMENT_EN     = 2;
	localparam int          B_TOP_SMM_SEGMENT_1M     = 3;
	localparam int          B_GMS_LO      = 4;
	localparam int          B_VGA_GFX     = 6;
	localparam int          B_HIGH_SMM_SEGMENT_EN     = 7;
	localparam int          B_APER_64M    = 8;
	localparam logic [8:0]  CTRL_RST      = 9'h000;
	localparam logic [7:0]  SHADOW_RST    = 8'h00;
	localparam logic [31:0] TOM_RST       = 32'h0100_0000;
	localparam logic [31:0] BASE_RST      = 32'h0000_0000;
	// ****************************************
	// address map
	// ****************************************
	localparam logic [31:0] VGA_LO        = 32'h000A_0000;
	localparam logic [31:0] SHADOW_LO     = 32'h000C_0000;
	localparam logic [31:0] ONE_MB        = 32'h0010_0000;
	localparam logic [31:0] CD_LO         = 32'h000D_C000;
	localparam logic [31:0] CD_HI         = 32'h000D_FFFF;
	localparam logic [31:0] ISA_LO        = 32'h00F0_0000;
	localparam logic [31:0] ISA_HI        = 32'h00FF_FFFF;
	localparam logic [31:0] HALF_MB       = 32'h0008_0000;
	localparam logic [31:0] MMIO_MASK     = 32'hFFF8_0000;
	localparam logic [31:0] AP32_MASK     = 32'hFE00_0000;
	localparam logic [31:0] AP64_MASK     = 32'hFC00_0000;
	localparam logic [31:0] APIC_LO       = 32'hFEC0_0000;
	localparam logic [31:0] APIC_HI       = 32'hFECF_FFFF;
	localparam logic [31:0] FIXED_LO      = 32'hFED0_0000;
	localparam logic [31:0] FIXED_HI      = 32'hFEDF_FFFF;
	localparam logic [31:0] LAPIC_LO      = 32'hFEE0_0000;
	localparam logic [31:0] LAPIC_HI      = 32'hFEEF_FFFF;
	localparam logic [31:0] HIGH_SMM_SEGMENT_LO       = 32'hFEEA_0000;
	localparam logic [31:0] HIGH_SMM_SEGMENT_HI       = 32'hFEEB_FFFF;
	localparam logic [31:0] HIGH_SMM_SEGMENT_OFS      = 32'hFEE0_0000;
	localparam logic [31:0] BIOS_LO       = 32'hFFE0_0000;
	// ****************************************
	// targets, one-hot
	// ****************************************
	localparam logic [3:0]  TGT_DRAM      = 4'h1;
	localparam logic [3:0]  TGT_HUB       = 4'h2;
	localparam logic [3:0]  TGT_GFX       = 4'h4;
	localparam logic [3:0]  TGT_LOCAL     = 4'h8;
endpackage

// ===== hdl/system_address_decoder.sv
// Behaviour
// R1 - above 4 GB: terminate, reads zero
// R2 - below 0A0000h always main DRAM
// R3 - video window steered by select bits
// R4 - video steering same for every source
// R5 - four shadow segments, independent read/write
// R6 - CD hole to hub when enabled
// R7 - 1 MB to top goes DRAM
// R8 - ISA hole 15-16 MB to hub
// R9 - top SMM segment below top, non-SMM hub
// R10 - graphics carve-out below SMM segment or top
// R11 - top to 4 GB goes hub
// R12 - 512 KB graphics register window
// R13 - aperture 32 or 64 MB at base
// R14 - I/O APIC slots forwarded to hub
// R15 - FED0_0000h-FEDF_FFFFh always hub
// R16 - top 2 MB boot firmware to hub
// R17 - high SMM segment maps onto video DRAM
// R18 - software keeps ranges non-overlapping
// R19 - one target, exceptions before base rule
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
module system_address_decoder (
	input  wire logic                                CLK_SYS,
	input  wire logic                                RESET,
	input  wire logic                                PSEL,
	input  wire logic                                PENABLE,
	input  wire logic                                PWRITE,
	input  wire logic [addr_decode_pkg::PADDR_W-1:0] PADDR,
	input  wire logic [31:0]                         PWDATA,
	output logic      [31:0]                         PRDATA,
	output logic                                     PREADY,
	output logic                                     PSLVERR,
	input  wire logic                                ACC_VALID,
	input  wire logic [35:0]                         ACC_ADDR,
	input  wire logic                                ACC_WRITE,
	input  wire logic                                ACC_HOST,
	input  wire logic                                ACC_SMM,
	output logic                                     DEC_VALID,
	output logic      [3:0]                          DEC_TARGET,
	output logic      [31:0]                         DEC_ADDR,
	output logic                                     DEC_RDZERO
);
	import addr_decode_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [CTL_W-1:0] ctrl;
		logic [7:0]       shadow;
		logic [31:0]      main_memory_top;
		logic [31:0]      mmio;
		logic [31:0]      aper;
		logic [31:0]      prdata;
		logic             pready;
		logic             pslverr;
		logic             dvalid;
		logic [3:0]       tgt;
		logic [31:0]      daddr;
		logic             rdzero;
	} state_t;

	state_t st_ff;
	state_t nxt_st;

	logic [31:0] a;
	logic [1:0]  graphics_mem_select;
	logic        gfx_en;
	logic [31:0] top_smm_segment_lo;
	logic [31:0] gfx_lo;
	logic [31:0] ap_mask;
	logic [1:0]  seg_attr;
	logic        vga_gfx;
	logic        hit_mmio;
	logic        hit_aper;
	logic        hit_high_smm_segment;
	logic        hit_isa;

	assign a = ACC_ADDR[31:0];
	assign graphics_mem_select = st_ff.ctrl[B_GMS_LO+:2];
	assign gfx_en = (graphics_mem_select != 2'h0);
	assign vga_gfx = gfx_en && st_ff.ctrl[B_VGA_GFX];
	assign ap_mask = st_ff.ctrl[B_APER_64M] ? AP64_MASK : AP32_MASK; // R13
	assign seg_attr = st_ff.shadow[{a[17:16], 1'b0}+:2];
	assign hit_mmio = ((a ^ st_ff.mmio) & MMIO_MASK) == 32'h0000_0000;
	assign hit_aper = ((a ^ st_ff.aper) & ap_mask) == 32'h0000_0000;
	assign hit_high_smm_segment = st_ff.ctrl[B_HIGH_SMM_SEGMENT_EN] && a >= HIGH_SMM_SEGMENT_LO && a <= HIGH_SMM_SEGMENT_HI;
	assign hit_isa = st_ff.ctrl[B_ISAHOLE] && a >= ISA_LO && a <= ISA_HI;

	// ****************************************
	// decode and registers
	// ****************************************
	always_comb begin
		nxt_st = st_ff;
		top_smm_segment_lo = st_ff.main_memory_top;
		if (st_ff.ctrl[B_TOP_SMM_SEGMENT_EN]) begin
			top_smm_segment_lo = st_ff.main_memory_top - (st_ff.ctrl[B_TOP_SMM_SEGMENT_1M] ? ONE_MB : HALF_MB); // R9
		end
		gfx_lo = top_smm_segment_lo;
		if (gfx_en) begin
			gfx_lo = top_smm_segment_lo - (graphics_mem_select[1] ? ONE_MB : HALF_MB); // R10
		end
		// apb slave, answers in the second access cycle
		nxt_st.pready = PSEL && PENABLE && !st_ff.pready;
		nxt_st.pslverr = 1'b0;
		if (PSEL && PENABLE && !st_ff.pready) begin
			nxt_st.prdata = 32'h0000_0000;
			unique case (PADDR)
				OFS_CTRL: begin
					nxt_st.prdata = {{(32-CTL_W){1'b0}}, st_ff.ctrl};
					if (PWRITE) begin
						nxt_st.ctrl = PWDATA[CTL_W-1:0];
					end
				end
				OFS_SHADOW: begin
					nxt_st.prdata = {24'h00_0000, st_ff.shadow};
					if (PWRITE) begin
						nxt_st.shadow = PWDATA[7:0];
					end
				end
				OFS_TOM: begin
					nxt_st.prdata = st_ff.main_memory_top;
					if (PWRITE) begin
						nxt_st.main_memory_top = PWDATA;
					end
				end
				OFS_MMIO: begin
					nxt_st.prdata = st_ff.mmio;
					if (PWRITE) begin
						nxt_st.mmio = PWDATA & MMIO_MASK;
					end
				end
				OFS_APER: begin
					nxt_st.prdata = st_ff.aper;
					if (PWRITE) begin
						nxt_st.aper = PWDATA & AP32_MASK;
					end
				end
				OFS_STATUS: begin
					nxt_st.prdata = {27'h000_0000, st_ff.dvalid, st_ff.tgt};
				end
				default: begin
					nxt_st.pslverr = 1'b1;
				end
			endcase
		end
		// access decode, result one cycle after the request
		nxt_st.dvalid = ACC_VALID;
		nxt_st.daddr = a;
		nxt_st.rdzero = 1'b0;
		nxt_st.tgt = TGT_HUB; // R19
		if (ACC_ADDR[35:32] != 4'h0) begin
			nxt_st.tgt = TGT_LOCAL; // R1
			nxt_st.rdzero = !ACC_WRITE; // R1
		end else if (st_ff.ctrl[B_HIGH_SMM_SEGMENT_EN] && a >= HIGH_SMM_SEGMENT_LO && a <= HIGH_SMM_SEGMENT_HI) begin
			nxt_st.tgt = TGT_DRAM; // R17
			nxt_st.daddr = a - HIGH_SMM_SEGMENT_OFS; // R17
		end else if (((a ^ st_ff.mmio) & MMIO_MASK) == 32'h0000_0000) begin
			nxt_st.tgt = TGT_GFX; // R12
		end else if (((a ^ st_ff.aper) & ap_mask) == 32'h0000_0000) begin
			nxt_st.tgt = TGT_GFX; // R13
		end else if (a >= APIC_LO && a <= APIC_HI) begin
			nxt_st.tgt = TGT_HUB; // R14
		end else if (a >= FIXED_LO && a <= FIXED_HI) begin
			nxt_st.tgt = TGT_HUB; // R15
		end else if (a >= LAPIC_LO && a <= LAPIC_HI) begin
			nxt_st.tgt = TGT_HUB;
		end else if (a >= BIOS_LO) begin
			nxt_st.tgt = TGT_HUB; // R16
		end else if (a < VGA_LO) begin
			nxt_st.tgt = TGT_DRAM; // R2
		end else if (a < SHADOW_LO) begin
			nxt_st.tgt = vga_gfx ? TGT_GFX : TGT_HUB; // R3 R4
		end else if (a < ONE_MB) begin
			if (st_ff.ctrl[B_CDHOLE] && a >= CD_LO && a <= CD_HI) begin
				nxt_st.tgt = TGT_HUB; // R6
			end else if (ACC_WRITE ? seg_attr[1] : seg_attr[0]) begin
				nxt_st.tgt = TGT_DRAM; // R5
			end
		end else if (a < st_ff.main_memory_top) begin
			if (st_ff.ctrl[B_ISAHOLE] && a >= ISA_LO && a <= ISA_HI) begin
				nxt_st.tgt = TGT_HUB; // R8
			end else if (st_ff.ctrl[B_TOP_SMM_SEGMENT_EN] && a >= top_smm_segment_lo) begin
				nxt_st.tgt = (ACC_HOST && ACC_SMM) ? TGT_DRAM : TGT_HUB; // R9
			end else if (gfx_en && a >= gfx_lo && a < top_smm_segment_lo) begin
				nxt_st.tgt = TGT_GFX; // R10
			end else begin
				nxt_st.tgt = TGT_DRAM; // R7
			end
		end else begin
			nxt_st.tgt = TGT_HUB; // R11
		end
	end

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			st_ff <= '{ctrl: CTRL_RST, shadow: SHADOW_RST, main_memory_top: TOM_RST, mmio: BASE_RST,
				aper: BASE_RST, prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0,
				dvalid: 1'b0, tgt: TGT_HUB, daddr: 32'h0000_0000, rdzero: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign PRDATA = st_ff.prdata;
	assign PREADY = st_ff.pready;
	assign PSLVERR = st_ff.pslverr;
	assign DEC_VALID = st_ff.dvalid;
	assign DEC_TARGET = st_ff.tgt;
	assign DEC_ADDR = st_ff.daddr;
	assign DEC_RDZERO = st_ff.rdzero;

	// ****************************************
	// assertions
	// ****************************************
	a_high_terminate: assert property (@(posedge CLK_SYS) disable iff (RESET) // R1
		ACC_VALID && ACC_ADDR[35:32] != 4'h0 |=> DEC_TARGET == TGT_LOCAL && DEC_RDZERO == !$past(ACC_WRITE))
		else $error("access above 4 GB not terminated");
	a_dos_dram: assert property (@(posedge CLK_SYS) disable iff (RESET) // R2
		ACC_VALID && ACC_ADDR < 36'h0_000A_0000 |=> DEC_VALID && DEC_TARGET == TGT_DRAM)
		else $error("dos area not sent to dram");
	a_vga_steer: assert property (@(posedge CLK_SYS) disable iff (RESET) // R3
		ACC_VALID && ACC_ADDR >= 36'h0_000A_0000 && ACC_ADDR < 36'h0_000C_0000
		|=> DEC_TARGET == ($past(vga_gfx) ? TGT_GFX : TGT_HUB))
		else $error("video window misrouted");
	a_cd_hole: assert property (@(posedge CLK_SYS) disable iff (RESET) // R6
		ACC_VALID && st_ff.ctrl[B_CDHOLE] && ACC_ADDR >= 36'h0_000D_C000 && ACC_ADDR < 36'h0_000E_0000
		|=> DEC_TARGET == TGT_HUB)
		else $error("cd hole not sent to hub");
	a_isa_hole: assert property (@(posedge CLK_SYS) disable iff (RESET) // R8
		ACC_VALID && st_ff.ctrl[B_ISAHOLE] && ACC_ADDR >= 36'h0_00F0_0000 && ACC_ADDR < 36'h0_0100_0000
		&& st_ff.main_memory_top > ISA_HI && ACC_ADDR < {4'h0, st_ff.mmio} |=> DEC_TARGET == TGT_HUB)
		else $error("isa hole not sent to hub");
	a_fixed_hub: assert property (@(posedge CLK_SYS) disable iff (RESET) // R15
		ACC_VALID && ACC_ADDR >= 36'h0_FED0_0000 && ACC_ADDR <= 36'h0_FEDF_FFFF
		&& ((a ^ st_ff.mmio) & MMIO_MASK) != 32'h0000_0000 && ((a ^ st_ff.aper) & ap_mask) != 32'h0000_0000
		|=> DEC_TARGET == TGT_HUB)
		else $error("fixed range not sent to hub");
	a_high_smm_segment_map: assert property (@(posedge CLK_SYS) disable iff (RESET) // R17
		ACC_VALID && st_ff.ctrl[B_HIGH_SMM_SEGMENT_EN] && ACC_ADDR >= 36'h0_FEEA_0000 && ACC_ADDR <= 36'h0_FEEB_FFFF
		|=> DEC_TARGET == TGT_DRAM && DEC_ADDR == $past(a) - HIGH_SMM_SEGMENT_OFS)
		else $error("high smm segment not translated");
	a_one_target: assert property (@(posedge CLK_SYS) disable iff (RESET) // R19
		DEC_VALID |-> $onehot(DEC_TARGET))
		else $error("target not one-hot");
	a_apb_answer: assert property (@(posedge CLK_SYS) disable iff (RESET)
		PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
		else $error("apb answer not one cycle");
	a_slverr_pair: assert property (@(posedge CLK_SYS) disable iff (RESET)
		PSLVERR |-> PREADY)
		else $error("slave error without ready");
	a_rdzero_local: assert property (@(posedge CLK_SYS) disable iff (RESET) // R1
		DEC_RDZERO |-> DEC_TARGET == TGT_LOCAL)
		else $error("zero read outside local termination");
	a_shadow_read: assert property (@(posedge CLK_SYS) disable iff (RESET) // R5
		ACC_VALID && ACC_ADDR[35:20] == 16'h0000 && a >= SHADOW_LO && !ACC_WRITE && !hit_mmio && !hit_aper
		&& !(st_ff.ctrl[B_CDHOLE] && a >= CD_LO && a <= CD_HI)
		|=> DEC_TARGET == ($past(seg_attr[0]) ? TGT_DRAM : TGT_HUB))
		else $error("shadow read misrouted");
	a_shadow_write: assert property (@(posedge CLK_SYS) disable iff (RESET) // R5
		ACC_VALID && ACC_ADDR[35:20] == 16'h0000 && a >= SHADOW_LO && ACC_WRITE && !hit_mmio && !hit_aper
		&& !(st_ff.ctrl[B_CDHOLE] && a >= CD_LO && a <= CD_HI)
		|=> DEC_TARGET == ($past(seg_attr[1]) ? TGT_DRAM : TGT_HUB))
		else $error("shadow write misrouted");
	a_main_dram: assert property (@(posedge CLK_SYS) disable iff (RESET) // R7
		ACC_VALID && ACC_ADDR[35:32] == 4'h0 && a >= ONE_MB && a < st_ff.main_memory_top && a < APIC_LO
		&& !hit_mmio && !hit_aper && !hit_isa && !(st_ff.ctrl[B_TOP_SMM_SEGMENT_EN] && a >= top_smm_segment_lo)
		&& !(gfx_en && a >= gfx_lo) |=> DEC_TARGET == TGT_DRAM)
		else $error("main memory not sent to dram");
	a_top_smm_segment_route: assert property (@(posedge CLK_SYS) disable iff (RESET) // R9
		ACC_VALID && ACC_ADDR[35:32] == 4'h0 && st_ff.ctrl[B_TOP_SMM_SEGMENT_EN] && a >= top_smm_segment_lo && a < st_ff.main_memory_top
		&& a >= ONE_MB && a < APIC_LO && !hit_mmio && !hit_aper && !hit_isa
		|=> DEC_TARGET == ($past(ACC_HOST && ACC_SMM) ? TGT_DRAM : TGT_HUB))
		else $error("top smm segment misrouted");
	a_gfx_carve: assert property (@(posedge CLK_SYS) disable iff (RESET) // R10
		ACC_VALID && ACC_ADDR[35:32] == 4'h0 && gfx_en && a >= gfx_lo && a < top_smm_segment_lo && a >= ONE_MB
		&& a < APIC_LO && !hit_mmio && !hit_aper && !hit_isa
		|=> DEC_TARGET == TGT_GFX)
		else $error("graphics carve-out misrouted");
	a_pci_hub: assert property (@(posedge CLK_SYS) disable iff (RESET) // R11
		ACC_VALID && ACC_ADDR[35:32] == 4'h0 && a >= st_ff.main_memory_top && a >= ONE_MB && a < APIC_LO
		&& !hit_mmio && !hit_aper
		|=> DEC_TARGET == TGT_HUB)
		else $error("pci range not sent to hub");
	a_mmio_window: assert property (@(posedge CLK_SYS) disable iff (RESET) // R12
		ACC_VALID && ACC_ADDR[35:32] == 4'h0 && hit_mmio && !hit_high_smm_segment
		|=> DEC_TARGET == TGT_GFX)
		else $error("register window not sent to graphics");
	a_aperture: assert property (@(posedge CLK_SYS) disable iff (RESET) // R13
		ACC_VALID && ACC_ADDR[35:32] == 4'h0 && hit_aper && !hit_mmio && !hit_high_smm_segment
		|=> DEC_TARGET == TGT_GFX)
		else $error("aperture not sent to graphics");
	a_apic_hub: assert property (@(posedge CLK_SYS) disable iff (RESET) // R14
		ACC_VALID && ACC_ADDR[35:32] == 4'h0 && a >= APIC_LO && a <= APIC_HI && !hit_mmio && !hit_aper
		|=> DEC_TARGET == TGT_HUB)
		else $error("apic range not sent to hub");
	a_bios_hub: assert property (@(posedge CLK_SYS) disable iff (RESET) // R16
		ACC_VALID && ACC_ADDR[35:32] == 4'h0 && a >= BIOS_LO && !hit_mmio && !hit_aper
		|=> DEC_TARGET == TGT_HUB)
		else $error("boot firmware not sent to hub");
	a_addr_pass: assert property (@(posedge CLK_SYS) disable iff (RESET) // R17
		ACC_VALID && !(ACC_ADDR[35:32] == 4'h0 && hit_high_smm_segment)
		|=> DEC_ADDR == $past(a))
		else $error("address changed outside high smm segment");
endmodule

// ===== test/access_source.sv
`timescale 1ns/1ps
module access_source (
	input  wire logic        clk,
	input  wire logic        req,
	input  wire logic [35:0] addr,
	input  wire logic        wr,
	input  wire logic        host,
	input  wire logic        smm,
	output logic             acc_valid,
	output logic [35:0]      acc_addr,
	output logic             acc_write,
	output logic             acc_host,
	output logic             acc_smm
);
	// ****************************************
	// far-side access driver
	// ****************************************
	logic [35:0] last = '0;
	always_ff @(posedge clk) begin
		if (req)
			last <= addr;
	end
	// idle cycles show the inverse of the last request address, with write, host and smm taken from its inverted low bits, never a stale copy
	always_comb begin
		acc_valid = req;
		acc_addr  = req ? addr : ~last;
		acc_write = req ? wr : ~last[0];
		acc_host  = req ? host : ~last[1];
		acc_smm   = req ? smm : ~last[2];
	end
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ps
module testbench;
	import addr_decode_pkg::*;
	logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, req = 0, wr = 0, host = 0, smm = 0;
	logic [7:0]  paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd, dec_addr;
	logic        pready, pslverr, dec_valid, dec_rdzero, acc_valid, acc_write, acc_host, acc_smm, err;
	logic [3:0]  dec_target;
	logic [35:0] addr = '0, acc_addr;
	int          n_errors = 0, checked = 0;
	// ****************************************
	// clock and instances
	// ****************************************
	always #5 clk = ~clk;
	access_source src (.clk(clk), .req(req), .addr(addr), .wr(wr), .host(host), .smm(smm),
		.acc_valid(acc_valid), .acc_addr(acc_addr), .acc_write(acc_write), .acc_host(acc_host),
		.acc_smm(acc_smm));
	system_address_decoder dut (.CLK_SYS(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .ACC_VALID(acc_valid), .ACC_ADDR(acc_addr), .ACC_WRITE(acc_write),
		.ACC_HOST(acc_host), .ACC_SMM(acc_smm), .DEC_VALID(dec_valid), .DEC_TARGET(dec_target),
		.DEC_ADDR(dec_addr), .DEC_RDZERO(dec_rdzero));
	// ****************************************
	// tasks
	// ****************************************
	task give_verdict;
		if (n_errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task cmp(input logic [35:0] seen, input logic [35:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel    <= 1;
		penable <= 0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		if (pready !== 1'b1) begin
			n_errors++;
			give_verdict;
		end
		rd  = prdata;
		err = pslverr;
		psel    <= 0;
		penable <= 0;
	endtask
	task acc(input logic [35:0] a, input logic w, hs, sm, input logic [3:0] t, input logic [31:0] xa);
		@(posedge clk);
		req  <= 1;
		addr <= a;
		wr   <= w;
		host <= hs;
		smm  <= sm;
		@(posedge clk);
		req <= 0;
		#1;
		cmp(36'(dec_valid), 36'h1);
		cmp(36'(dec_target), 36'(t));
		cmp(36'(dec_addr), 36'(xa != 0 ? xa : a[31:0]));
		cmp(36'(dec_rdzero), 36'(t == TGT_LOCAL && !w));
	endtask
	// ****************************************
	// sequence
	// ****************************************
	initial begin
		repeat (20) @(posedge clk);
		rst <= 0;
		apb(0, OFS_TOM, 0);
		cmp(36'(rd), 36'(TOM_RST));
		apb(0, 8'h18, 0);
		cmp(36'({err, rd}), 36'h1_0000_0000);
		apb(1, OFS_MMIO, 32'h8000_0000);
		apb(1, OFS_APER, 32'hC000_0000);
		apb(1, OFS_TOM, 32'h0200_0000);
		acc(36'h0_0009_FFFF, 0, 1, 0, TGT_DRAM, 0);
		acc(36'h1_0000_0000, 0, 1, 0, TGT_LOCAL, 0);
		acc(36'h1_0000_0040, 1, 1, 0, TGT_LOCAL, 0);
		acc(36'h0_000A_0000, 0, 1, 0, TGT_HUB, 0);
		acc(36'h0_000C_0000, 0, 1, 0, TGT_HUB, 0);
		acc(36'h0_0010_0000, 0, 0, 0, TGT_DRAM, 0);
		acc(36'h0_00F0_0000, 0, 1, 0, TGT_DRAM, 0);
		acc(36'h0_01FF_FFFF, 1, 1, 0, TGT_DRAM, 0);
		acc(36'h0_0200_0000, 0, 1, 0, TGT_HUB, 0);
		acc(36'h0_FEC0_1000, 0, 1, 0, TGT_HUB, 0);
		acc(36'h0_FEDF_FFFF, 0, 0, 0, TGT_HUB, 0);
		acc(36'h0_FFE0_0000, 0, 1, 0, TGT_HUB, 0);
		acc(36'h0_8007_FFFF, 0, 1, 0, TGT_GFX, 0);
		acc(36'h0_8008_0000, 0, 1, 0, TGT_HUB, 0);
		acc(36'h0_C1FF_FFFF, 0, 1, 0, TGT_GFX, 0);
		acc(36'h0_C200_0000, 0, 1, 0, TGT_HUB, 0);
		apb(1, OFS_CTRL, 32'h0000_01D7);
		apb(1, OFS_SHADOW, 32'h0000_002D);
		acc(36'h0_000A_0000, 0, 1, 0, TGT_GFX, 0);
		acc(36'h0_000B_FFFF, 1, 0, 0, TGT_GFX, 0);
		acc(36'h0_000C_0000, 0, 1, 0, TGT_DRAM, 0);
		acc(36'h0_000C_0000, 1, 1, 0, TGT_HUB, 0);
		acc(36'h0_000E_0000, 0, 1, 0, TGT_HUB, 0);
		acc(36'h0_000E_0000, 1, 1, 0, TGT_DRAM, 0);
		acc(36'h0_000F_0000, 0, 1, 0, TGT_HUB, 0);
		acc(36'h0_000D_C000, 0, 1, 0, TGT_HUB, 0);
		acc(36'h0_00F0_0000, 0, 1, 0, TGT_HUB, 0);
		acc(36'h0_01F8_0000, 0, 1, 1, TGT_DRAM, 0);
		acc(36'h0_01FF_FFFF, 0, 1, 0, TGT_HUB, 0);
		acc(36'h0_01F8_0000, 0, 0, 1, TGT_HUB, 0);
		acc(36'h0_01EF_FFFF, 0, 1, 0, TGT_DRAM, 0);
		acc(36'h0_01F0_0000, 0, 1, 0, TGT_GFX, 0);
		acc(36'h0_01F7_FFFF, 1, 0, 0, TGT_GFX, 0);
		acc(36'h0_C3FF_FFFF, 0, 1, 0, TGT_GFX, 0);
		acc(36'h0_FEEA_0004, 0, 0, 0, TGT_DRAM, 32'h000A_0004);
		acc(36'h0_FEEB_FFFF, 1, 1, 0, TGT_DRAM, 32'h000B_FFFF);
		apb(1, OFS_CTRL, 32'h0000_01FE);
		acc(36'h0_000D_C000, 0, 1, 0, TGT_DRAM, 0);
		acc(36'h0_01F0_0000, 0, 1, 1, TGT_DRAM, 0);
		acc(36'h0_01F0_0000, 1, 1, 0, TGT_HUB, 0);
		acc(36'h0_01DF_FFFF, 0, 1, 0, TGT_DRAM, 0);
		acc(36'h0_01E0_0000, 0, 1, 0, TGT_GFX, 0);
		acc(36'h0_01EF_FFFF, 1, 1, 1, TGT_GFX, 0);
		acc(36'h1_FFFF_FFFF, 0, 1, 1, TGT_LOCAL, 0);
		give_verdict;
	end
endmodule
